// ==== hdl/rtcaw_pkg.sv ====
package rtcaw_pkg;

  localparam int unsigned XTAL_PER_SEC = 32768;
  localparam int unsigned MS_PER_SEC = 1000;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_MATCH = 8'h08;
  localparam logic [7:0] OFF_WKT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;

  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CB_WKT_EN = 0;
  localparam int unsigned CB_ALM_WAKE = 1;
  localparam int unsigned CB_WKT_WAKE = 2;
  localparam int unsigned CB_SYSCLK_SEL = 3;
  localparam int unsigned CB_CLOCK_OUTPUT_PIN_SEL = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  localparam int unsigned NSRC = 2;
  localparam int unsigned SB_ALARM = 0;
  localparam int unsigned SB_WKT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;

  typedef enum logic {WKT_IDLE, WKT_RUN} rtcaw_wkt_t;

endpackage : rtcaw_pkg

// ==== hdl/rtcaw_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtcaw_top
  import rtcaw_pkg::*;
#(
  parameter int unsigned COUNT_W = 32,
  parameter int unsigned WKT_W = 16,
  parameter int unsigned XTAL_DIV = XTAL_PER_SEC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic XTAL_32K,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic ALARM_IRQ,
  output logic WAKE_IRQ,
  output logic IRQ,
  output logic WAKE_REQ,
  output logic SYSCLK_XTAL_SEL,
  output logic CLOCK_OUTPUT_PIN
);

  localparam int unsigned DIV_W = $clog2(XTAL_DIV);
  localparam logic [DIV_W:0] DIV_TOP = (DIV_W + 1)'(XTAL_DIV);
  localparam logic [DIV_W:0] MS_STEP = (DIV_W + 1)'(MS_PER_SEC);

  generate
    if (COUNT_W < 8 || COUNT_W > 32 || WKT_W < 2 || WKT_W > 32 ||
        XTAL_DIV <= MS_PER_SEC) begin : g_bad
      $error("rtcaw_top: unsupported parameter values");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // register strobes

  logic wr_ctrl;
  logic wr_count;
  logic wr_match;
  logic wr_wkt;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl = WR && hit(ADDR, OFF_CTRL);
  assign wr_count = WR && hit(ADDR, OFF_COUNT);
  assign wr_match = WR && hit(ADDR, OFF_MATCH);
  assign wr_wkt = WR && hit(ADDR, OFF_WKT);
  assign wr_status = WR && hit(ADDR, OFF_STATUS);
  assign wr_mask = WR && hit(ADDR, OFF_MASK);

  logic [CTRL_W-1:0] ctrl_ff;
  logic [NSRC-1:0] mask_ff;
  logic [COUNT_W-1:0] match_ff;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      match_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= WDATA[CTRL_W-1:0];
      end
      if (wr_mask) begin
        mask_ff <= WDATA[NSRC-1:0];
      end
      if (wr_match) begin
        match_ff <= WDATA[COUNT_W-1:0];
      end
    end
  end

  logic wkt_en;
  assign wkt_en = ctrl_ff[CB_WKT_EN];

  ////////////////////////////////////////////////////////////////////////
  // crystal edge detect and dividers

  logic xtal_q_ff;
  logic xedge;
  logic [DIV_W-1:0] sec_div_ff;
  logic [DIV_W:0] ms_acc_ff;
  logic [DIV_W:0] ms_sum;
  logic tick_1hz;
  logic tick_1k;

  assign xedge = XTAL_32K && !xtal_q_ff;
  assign tick_1hz = xedge && ({1'b0, sec_div_ff} == DIV_TOP - 1'b1);
  // 32768 is not a multiple of 1000: phase accumulator, 1 ms on average
  assign ms_sum = ms_acc_ff + MS_STEP;
  assign tick_1k = wkt_en && xedge && (ms_sum >= DIV_TOP);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xtal_q_ff <= 1'b0;
    end else begin
      xtal_q_ff <= XTAL_32K;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sec_div_ff <= '0;
    end else if (tick_1hz) begin
      sec_div_ff <= '0;
    end else if (xedge) begin
      sec_div_ff <= sec_div_ff + 1'b1;
    end
  end

  // accumulator held at zero while the wake timer is off, to save power
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms_acc_ff <= '0;
    end else if (!wkt_en) begin
      ms_acc_ff <= '0;
    end else if (xedge) begin
      ms_acc_ff <= tick_1k ? ms_sum - DIV_TOP : ms_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // seconds counter and alarm

  logic [COUNT_W-1:0] cnt_ff;
  logic [COUNT_W-1:0] nxt_cnt;
  logic alarm_ev;

  assign nxt_cnt = cnt_ff + 1'b1;
  // alarm fires on the tick that brings the count onto the match value
  assign alarm_ev = tick_1hz && !wr_count && (nxt_cnt == match_ff);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_ff <= '0;
    end else if (wr_count) begin
      cnt_ff <= WDATA[COUNT_W-1:0];
    end else if (tick_1hz) begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-shot wake timer

  rtcaw_wkt_t wkt_st_ff;
  logic [WKT_W-1:0] wkt_cnt_ff;
  logic wkt_ev;
  logic wkt_load;

  assign wkt_load = wr_wkt && wkt_en;
  assign wkt_ev = (wkt_load && (WDATA[WKT_W-1:0] == '0)) ||
                  (!wr_wkt && wkt_st_ff == WKT_RUN && tick_1k &&
                   wkt_cnt_ff == WKT_W'(1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wkt_st_ff <= WKT_IDLE;
      wkt_cnt_ff <= '0;
    end else if (!wkt_en) begin
      wkt_st_ff <= WKT_IDLE;
    end else if (wkt_load) begin
      wkt_cnt_ff <= WDATA[WKT_W-1:0];
      wkt_st_ff <= (WDATA[WKT_W-1:0] == '0) ? WKT_IDLE : WKT_RUN;
    end else begin
      case (wkt_st_ff)
        WKT_RUN: begin
          if (tick_1k) begin
            wkt_cnt_ff <= wkt_cnt_ff - 1'b1;
            if (wkt_cnt_ff == WKT_W'(1)) begin
              wkt_st_ff <= WKT_IDLE;
            end
          end
        end
        default: begin
          wkt_st_ff <= WKT_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, interrupt lines, wake request

  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] st_ff;
  logic [NSRC-1:0] wake_en;

  assign ev[SB_ALARM] = alarm_ev;
  assign ev[SB_WKT] = wkt_ev;
  assign wake_en[SB_ALARM] = ctrl_ff[CB_ALM_WAKE];
  assign wake_en[SB_WKT] = ctrl_ff[CB_WKT_WAKE];

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_st
      // a new event beats a same-cycle write-one clear
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          st_ff[gi] <= 1'b0;
        end else begin
          st_ff[gi] <= ev[gi] || (st_ff[gi] && !(wr_status && WDATA[gi]));
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ALARM_IRQ <= 1'b0;
      WAKE_IRQ <= 1'b0;
      IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      ALARM_IRQ <= st_ff[SB_ALARM] && mask_ff[SB_ALARM];
      WAKE_IRQ <= st_ff[SB_WKT] && mask_ff[SB_WKT];
      IRQ <= |(st_ff & mask_ff);
      // wake is independent of the mask so a sleeping core still wakes
      WAKE_REQ <= |(st_ff & wake_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock source offer

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYSCLK_XTAL_SEL <= 1'b0;
      CLOCK_OUTPUT_PIN <= 1'b0;
    end else begin
      SYSCLK_XTAL_SEL <= ctrl_ff[CB_SYSCLK_SEL];
      CLOCK_OUTPUT_PIN <= ctrl_ff[CB_CLOCK_OUTPUT_PIN_SEL] && xtal_q_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= '0;
    end else if (!RD) begin
      RDATA <= '0;
    end else if (hit(ADDR, OFF_CTRL)) begin
      RDATA <= 32'(ctrl_ff);
    end else if (hit(ADDR, OFF_COUNT)) begin
      RDATA <= 32'(cnt_ff);
    end else if (hit(ADDR, OFF_MATCH)) begin
      RDATA <= 32'(match_ff);
    end else if (hit(ADDR, OFF_WKT)) begin
      RDATA <= 32'(wkt_cnt_ff);
    end else if (hit(ADDR, OFF_STATUS)) begin
      RDATA <= 32'(st_ff);
    end else if (hit(ADDR, OFF_MASK)) begin
      RDATA <= 32'(mask_ff);
    end else begin
      RDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_sec_advance: assert property (tick_1hz && !wr_count |=> cnt_ff == $past(nxt_cnt))
    else $error("seconds counter missed a tick");
  a_sec_hold: assert property (!tick_1hz && !wr_count |=> $stable(cnt_ff))
    else $error("seconds counter moved without a tick");
  a_div_wrap: assert property (tick_1hz |=> sec_div_ff == '0 ##1 !tick_1hz)
    else $error("1 Hz divider did not wrap");
  // line follows flag and mask one cycle late; other sources must not disturb it
  a_alarm_flag: assert property (alarm_ev
    |=> st_ff[SB_ALARM] ##1 ALARM_IRQ == $past(mask_ff[SB_ALARM]))
    else $error("alarm did not set its flag");
  a_wkt_count: assert property (wkt_st_ff == WKT_RUN && tick_1k && !wr_wkt && wkt_cnt_ff > 1
    |=> wkt_st_ff == WKT_RUN && wkt_cnt_ff == $past(wkt_cnt_ff) - 1'b1)
    else $error("wake timer did not count down");
  a_wkt_expire: assert property (wkt_st_ff == WKT_RUN && tick_1k && !wr_wkt &&
    wkt_cnt_ff == WKT_W'(1) |=> wkt_st_ff == WKT_IDLE && wkt_cnt_ff == '0 && st_ff[SB_WKT])
    else $error("wake timer did not stop at zero");
  a_wkt_off: assert property (!wkt_en |=> wkt_st_ff == WKT_IDLE && !tick_1k)
    else $error("disabled wake timer still running");
  a_irq_lines: assert property (st_ff[SB_WKT] && mask_ff[SB_WKT] && !st_ff[SB_ALARM]
    |=> WAKE_IRQ && !ALARM_IRQ)
    else $error("interrupt lines not independent");
  a_flag_sticky: assert property (st_ff[SB_ALARM] && !(wr_status && WDATA[SB_ALARM])
    |=> st_ff[SB_ALARM])
    else $error("status flag dropped without clear");
  a_wake_out: assert property ((st_ff & wake_en) != '0 |=> WAKE_REQ)
    else $error("wake request not raised");
  a_clock_output_pin_off: assert property (!ctrl_ff[CB_CLOCK_OUTPUT_PIN_SEL] |=> !CLOCK_OUTPUT_PIN)
    else $error("clock output driven while deselected");

endmodule : rtcaw_top

`default_nettype wire

// ==== verif/rtcaw_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module rtcaw_top_tb;
  import rtcaw_pkg::*;
  // short second keeps the run small; must stay above 1000
  localparam int unsigned XDIV = 2000;
  localparam int SEC = 2 * XDIV;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic xtal = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic alarm_irq, wake_irq, irq, wake_req, sys_sel, clk_pin;
  logic [31:0] a, b;
  logic [1:0] s;
  int num_errors = 0;
  int check_count = 0;
  int i;

  always #5 clk = ~clk;
  // crystal rises every second cycle, so one second is SEC cycles
  always @(posedge clk) xtal <= ~xtal;

  rtcaw_top #(.XTAL_DIV(XDIV)) u_rtcaw_top (
    .CLK(clk), .ARST_N(arst_n), .XTAL_32K(xtal), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ALARM_IRQ(alarm_irq), .WAKE_IRQ(wake_irq),
    .IRQ(irq), .WAKE_REQ(wake_req), .SYSCLK_XTAL_SEL(sys_sel), .CLOCK_OUTPUT_PIN(clk_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(ad, d);
    `CHK(nm, exp, d)
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("lines", 6'h00, {alarm_irq, wake_irq, irq, wake_req, sys_sel, clk_pin})
    rd_chk("ctrl", OFF_CTRL, 32'h0);
    rd_chk("status", OFF_STATUS, 32'h0);
    rd_chk("mask", OFF_MASK, 32'h0);
    bus_wr(8'h18, 32'hffffffff);
    rd_chk("unmapped", 8'h18, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_alarm;
    bus_wr(OFF_MASK, 32'h1);
    bus_wr(OFF_CTRL, 32'h2);
    bus_wr(OFF_MATCH, 32'h6);
    bus_wr(OFF_COUNT, 32'h5);
    for (i = 0; i < SEC + 20 && alarm_irq !== 1'b1; i++) @(posedge clk);
    #1;
    `CHK("alarm_irq", 1'b1, alarm_irq)
    `CHK("wake/irq/req", 3'b011, {wake_irq, irq, wake_req})
    rd_chk("count at match", OFF_COUNT, 32'h6);
    rd_chk("match", OFF_MATCH, 32'h6);
    settle(SEC + 10);
    rd_chk("count next sec", OFF_COUNT, 32'h7);
    rd_chk("alarm sticky", OFF_STATUS, 32'h1);
    bus_wr(OFF_STATUS, 32'h1);
    settle(2);
    `CHK("alarm cleared", 3'b000, {alarm_irq, irq, wake_req})
    bus_wr(OFF_COUNT, 32'hffffffff);
    settle(SEC + 10);
    rd_chk("count wrap", OFF_COUNT, 32'h0);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_wkt;
    bus_wr(OFF_MASK, 32'h0);
    bus_wr(OFF_CTRL, 32'h5);
    bus_wr(OFF_WKT, 32'h3);
    settle(40);
    rd_chk("wkt stopped", OFF_WKT, 32'h0);
    rd_chk("wkt flag", OFF_STATUS, 32'h2);
    // masked out: no interrupt line, but wake still requested
    `CHK("masked", 4'b0001, {alarm_irq, wake_irq, irq, wake_req})
    bus_wr(OFF_MASK, 32'h2);
    settle(2);
    `CHK("unmasked", 4'b0111, {alarm_irq, wake_irq, irq, wake_req})
    // flag still set: dropping the wake enable must drop only the wake request
    bus_wr(OFF_CTRL, 32'h1);
    settle(2);
    `CHK("wake gated", 2'b10, {wake_irq, wake_req})
    bus_wr(OFF_STATUS, 32'h2);
    bus_wr(OFF_WKT, 32'd200);
    settle(20);
    bus_wr(OFF_CTRL, 32'h0);
    bus_rd(OFF_WKT, a);
    `CHK("wkt counting", 1'b1, (a < 32'd200) && (a != 32'h0))
    bus_wr(OFF_WKT, 32'h7);
    settle(100);
    bus_rd(OFF_WKT, b);
    `CHK("wkt held", a, b)
    rd_chk("no flag", OFF_STATUS, 32'h0);
    $display("test wake timer done");
  endtask : t_wkt

  task automatic t_clk;
    bus_wr(OFF_CTRL, 32'h18);
    settle(2);
    `CHK("sysclk sel", 1'b1, sys_sel)
    s = 2'b00;
    repeat (4) begin
      settle(1);
      s = s | {clk_pin, ~clk_pin};
    end
    `CHK("pin toggles", 2'b11, s)
    bus_wr(OFF_CTRL, 32'h0);
    settle(2);
    s = 2'b00;
    repeat (4) begin
      settle(1);
      s = s | {clk_pin, sys_sel};
    end
    `CHK("pin off", 2'b00, s)
    $display("test clock select done");
  endtask : t_clk

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    settle(1);
    t_reset();
    t_alarm();
    t_wkt();
    t_clk();
    close_out();
  end

  // three seconds plus bus traffic fit well inside this span
  initial begin
    #(10 * 8 * SEC);
    num_errors++;
    close_out();
  end
endmodule : rtcaw_top_tb
`default_nettype wire
